/* File: src/mvdr_pkg.sv */
// constants, field layouts and carrier types of the paravirtual
// device register bank.
// assumes one 10 MHz clock domain and a 32-bit little-endian bus port.
package mvdr_pkg;

    // =========================================================
    // sizes
    localparam int ADDR_W = 12;
    localparam int NUM_RINGS = 4;
    localparam int RING_IDX_W = 2;
    localparam int CFG_BYTES = 16;
    localparam int CFG_IDX_W = 4;
    localparam int FLAG_WORDS = 2;

    // =========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_OFFERED_WORD = 12'h010;
    localparam logic [11:0] OFS_OFFERED_PICK = 12'h014;
    localparam logic [11:0] OFS_ACCEPTED_WORD = 12'h020;
    localparam logic [11:0] OFS_ACCEPTED_PICK = 12'h024;
    localparam logic [11:0] OFS_RING_PICK = 12'h030;
    localparam logic [11:0] OFS_RING_LIMIT = 12'h034;
    localparam logic [11:0] OFS_RING_DEPTH = 12'h038;
    localparam logic [11:0] OFS_RING_GO = 12'h044;
    localparam logic [11:0] OFS_DOORBELL = 12'h050;
    localparam logic [11:0] OFS_IRQ_CAUSE = 12'h060;
    localparam logic [11:0] OFS_IRQ_CLEAR = 12'h064;
    localparam logic [11:0] OFS_PROGRESS = 12'h070;
    localparam logic [11:0] OFS_DESC_LO = 12'h080;
    localparam logic [11:0] OFS_DESC_HI = 12'h084;
    localparam logic [11:0] OFS_OFFER_LO = 12'h090;
    localparam logic [11:0] OFS_OFFER_HI = 12'h094;
    localparam logic [11:0] OFS_DONE_LO = 12'h0a0;
    localparam logic [11:0] OFS_DONE_HI = 12'h0a4;
    localparam logic [11:0] OFS_EPOCH = 12'h0fc;
    localparam logic [11:0] OFS_CFG_BASE = 12'h100;

    // =========================================================
    // fields and reset values
    localparam int CAUSE_USED_BIT = 0;
    localparam int CAUSE_CFG_BIT = 1;
    localparam logic [1:0] CAUSE_DEFINED = 2'h3;
    localparam logic [15:0] RING_DEPTH_LIMIT = 16'h0100;
    localparam logic [31:0] PROGRESS_RESET = 32'h0000_0000;
    localparam logic [31:0] EPOCH_RESET = 32'h0000_0000;
    localparam logic [31:0] PICK_RESET = 32'h0000_0000;

    // =========================================================
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } mvdr_req_t;

    typedef struct packed {
        logic [15:0] depth;
        logic go;
        logic [63:0] descBase;
        logic [63:0] offerBase;
        logic [63:0] doneBase;
    } mvdr_ring_t;

endpackage

/* File: src/mvdr_regs.sv */
// memory-mapped control register bank of a paravirtual device:
// feature negotiation, per-ring setup, doorbell, interrupt cause,
// progress flags with soft reset, settings epoch and settings space.
// assumes the bus master and the ring engine run on mclk; no crossing.
`timescale 1ns/10ps

module mvdr_regs
    import mvdr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // driver register port
    input mvdr_req_t busReq,
    output logic [31:0] rdData,
    output logic rdValid,
    // ring engine side
    input wire logic [63:0] offeredFlags,
    input wire logic usedRingEvt,
    input wire logic [RING_IDX_W-1:0] viewIdx,
    output mvdr_ring_t viewRing,
    output logic [NUM_RINGS-1:0] ringGoMask,
    output logic doorbellPulse,
    output logic [31:0] doorbellIndex,
    // settings space updates made by the device itself
    input wire logic devCfgWr,
    input wire logic [CFG_IDX_W-1:0] devCfgIdx,
    input wire logic [7:0] devCfgByte,
    // status toward the device
    output logic [63:0] acceptedFlags,
    output logic [31:0] progressFlags,
    output logic deviceResetPulse,
    output logic irqOut
);

    // =========================================================
    // helpers

    // merge a written word into an old one under byte enables
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = newVal[8*i +: 8];
            end
        end
        return res;
    endfunction

    // does a 32-bit selector name an existing ring
    function automatic logic ringExists(input logic [31:0] pick);
        return pick < NUM_RINGS;
    endfunction

    // =========================================================
    // decode
    logic wrHit;
    logic rdHit;
    logic cfgArea;
    logic softReset;
    logic pickOk;
    logic [RING_IDX_W-1:0] pickIdx;
    logic [CFG_IDX_W-1:0] cfgWordIdx;
    logic [31:0] offeredPick_reg;
    logic [31:0] acceptedPick_reg;
    logic [31:0] ringPick_reg;
    logic [1:0] cause_reg;
    logic [1:0] ackMask;
    logic [31:0] epoch_reg;
    logic [7:0] cfgSpace_reg [CFG_BYTES];
    logic cfgDriverWr;
    mvdr_ring_t rings_reg [NUM_RINGS];
    logic [31:0] rdWord;
    logic [31:0] cfgWord;

    assign wrHit = busReq.wr;
    assign rdHit = busReq.rd;
    assign cfgArea = busReq.addr >= OFS_CFG_BASE;
    assign pickOk = ringExists(ringPick_reg);
    assign pickIdx = ringPick_reg[RING_IDX_W-1:0];
    // settings space is word addressed on the bus, bytes picked by lanes
    assign cfgWordIdx = {busReq.addr[CFG_IDX_W-1:2], 2'b00};
    assign cfgDriverWr = wrHit && cfgArea
        && (busReq.addr - OFS_CFG_BASE) < 12'(CFG_BYTES);
    // write of zero to progress is the soft reset
    assign softReset = wrHit && busReq.addr == OFS_PROGRESS
        && busReq.wdata == 32'h0000_0000;
    assign ackMask = (wrHit && busReq.addr == OFS_IRQ_CLEAR)
        ? busReq.wdata[1:0] & CAUSE_DEFINED : 2'b00;

    // =========================================================
    // selectors
    // selectors only steer; out-of-range values are kept but act on nothing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            offeredPick_reg <= PICK_RESET;
            acceptedPick_reg <= PICK_RESET;
            ringPick_reg <= PICK_RESET;
        end else if (softReset) begin
            offeredPick_reg <= PICK_RESET;
            acceptedPick_reg <= PICK_RESET;
            ringPick_reg <= PICK_RESET;
        end else if (wrHit) begin
            case (busReq.addr)
                OFS_OFFERED_PICK: offeredPick_reg <= busReq.wdata;
                OFS_ACCEPTED_PICK: acceptedPick_reg <= busReq.wdata;
                OFS_RING_PICK: ringPick_reg <= busReq.wdata;
                default: ;
            endcase
        end
    end

    // =========================================================
    // accepted feature flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acceptedFlags <= 64'h0;
        end else if (softReset) begin
            acceptedFlags <= 64'h0;
        end else if (wrHit && busReq.addr == OFS_ACCEPTED_WORD) begin
            // words beyond the implemented flags are dropped
            if (acceptedPick_reg < FLAG_WORDS) begin
                acceptedFlags[32*acceptedPick_reg[0] +: 32] <=
                    busReq.wdata;
            end
        end
    end

    // =========================================================
    // per-ring setup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int q = 0; q < NUM_RINGS; q++) begin
                rings_reg[q] <= '0;
            end
        end else if (softReset) begin
            for (int q = 0; q < NUM_RINGS; q++) begin
                rings_reg[q] <= '0;
            end
        end else if (wrHit && pickOk) begin
            case (busReq.addr)
                OFS_RING_DEPTH:
                    rings_reg[pickIdx].depth <= busReq.wdata[15:0];
                OFS_RING_GO:
                    rings_reg[pickIdx].go <= busReq.wdata[0];
                OFS_DESC_LO:
                    rings_reg[pickIdx].descBase[31:0] <= busReq.wdata;
                OFS_DESC_HI:
                    rings_reg[pickIdx].descBase[63:32] <=
                        busReq.wdata;
                OFS_OFFER_LO:
                    rings_reg[pickIdx].offerBase[31:0] <=
                        busReq.wdata;
                OFS_OFFER_HI:
                    rings_reg[pickIdx].offerBase[63:32] <=
                        busReq.wdata;
                OFS_DONE_LO:
                    rings_reg[pickIdx].doneBase[31:0] <= busReq.wdata;
                OFS_DONE_HI:
                    rings_reg[pickIdx].doneBase[63:32] <=
                        busReq.wdata;
                default: ;
            endcase
        end
    end

    // go bits and the engine's view of one ring
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ringGoMask <= '0;
            viewRing <= '0;
        end else begin
            for (int q = 0; q < NUM_RINGS; q++) begin
                ringGoMask[q] <= rings_reg[q].go;
            end
            viewRing <= rings_reg[viewIdx];
        end
    end

    // =========================================================
    // doorbell
    // one pulse per write; the index is passed on unchecked
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            doorbellPulse <= 1'b0;
            doorbellIndex <= 32'h0;
        end else begin
            doorbellPulse <= wrHit && busReq.addr == OFS_DOORBELL;
            if (wrHit && busReq.addr == OFS_DOORBELL) begin
                doorbellIndex <= busReq.wdata;
            end
        end
    end

    // =========================================================
    // interrupt cause
    // a new event in the acknowledge cycle survives: set beats clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cause_reg <= 2'b00;
        end else if (softReset) begin
            cause_reg <= 2'b00;
        end else begin
            cause_reg[CAUSE_USED_BIT] <= (cause_reg[CAUSE_USED_BIT]
                & ~ackMask[CAUSE_USED_BIT]) | usedRingEvt;
            cause_reg[CAUSE_CFG_BIT] <= (cause_reg[CAUSE_CFG_BIT]
                & ~ackMask[CAUSE_CFG_BIT]) | devCfgWr;
        end
    end

    // interrupt line follows the registered cause bits one cycle later
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(cause_reg & CAUSE_DEFINED);
        end
    end

    // =========================================================
    // progress flags and soft reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            progressFlags <= PROGRESS_RESET;
            deviceResetPulse <= 1'b0;
        end else begin
            deviceResetPulse <= softReset;
            if (softReset) begin
                progressFlags <= PROGRESS_RESET;
            end else if (wrHit && busReq.addr == OFS_PROGRESS) begin
                progressFlags <= progressFlags | busReq.wdata;
            end
        end
    end

    // =========================================================
    // settings space and epoch
    // device updates win over a driver write to the same byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < CFG_BYTES; b++) begin
                cfgSpace_reg[b] <= 8'h00;
            end
        end else begin
            if (cfgDriverWr) begin
                for (int i = 0; i < 4; i++) begin
                    if (busReq.be[i]) begin
                        cfgSpace_reg[cfgWordIdx + CFG_IDX_W'(i)] <=
                            busReq.wdata[8*i +: 8];
                    end
                end
            end
            if (devCfgWr) begin
                cfgSpace_reg[devCfgIdx] <= devCfgByte;
            end
        end
    end

    // any content change moves the epoch, so a torn read is detectable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            epoch_reg <= EPOCH_RESET;
        end else if (devCfgWr || (cfgDriverWr && busReq.be != 4'h0)) begin
            epoch_reg <= epoch_reg + 32'h1;
        end
    end

    // =========================================================
    // read mux
    always_comb begin
        cfgWord = 32'h0;
        for (int i = 0; i < 4; i++) begin
            cfgWord[8*i +: 8] = cfgSpace_reg[cfgWordIdx + CFG_IDX_W'(i)];
        end
        rdWord = 32'h0;
        case (busReq.addr)
            OFS_OFFERED_WORD: begin
                if (offeredPick_reg < FLAG_WORDS) begin
                    rdWord = offeredFlags[32*offeredPick_reg[0] +: 32];
                end
            end
            OFS_RING_LIMIT: begin
                rdWord = pickOk ? {16'h0, RING_DEPTH_LIMIT} : 32'h0;
            end
            OFS_RING_GO: begin
                rdWord = pickOk ? {31'h0, rings_reg[pickIdx].go}
                    : 32'h0;
            end
            OFS_IRQ_CAUSE: begin
                rdWord = {30'h0, cause_reg};
            end
            OFS_PROGRESS: begin
                rdWord = progressFlags;
            end
            OFS_EPOCH: begin
                rdWord = epoch_reg;
            end
            default: begin
                if (cfgDriverWr || (cfgArea
                    && (busReq.addr - OFS_CFG_BASE) < 12'(CFG_BYTES))) begin
                    // byte lanes not enabled read as zero
                    rdWord = mergeBytes(32'h0, cfgWord, busReq.be);
                end
            end
        endcase
    end

    // read answer one cycle after the request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData <= 32'h0;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdHit;
            if (rdHit) begin
                rdData <= rdWord;
            end
        end
    end

endmodule

/* File: tb/mvdr_regs_props.sv */
// concurrent checks on the ports of the register bank.
// assumes mvdr_pkg is compiled first; bound onto every mvdr_regs.
`timescale 1ns/10ps

// ==========================================================
// checker
module mvdr_regs_props
    import mvdr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // driver port
    input wire mvdr_req_t busReq,
    input wire logic [31:0] rdData,
    input wire logic rdValid,
    // ring engine side
    input wire logic [63:0] offeredFlags,
    input wire logic usedRingEvt,
    input wire logic [RING_IDX_W-1:0] viewIdx,
    input wire mvdr_ring_t viewRing,
    input wire logic [NUM_RINGS-1:0] ringGoMask,
    input wire logic doorbellPulse,
    input wire logic [31:0] doorbellIndex,
    // settings updates by the device
    input wire logic devCfgWr,
    input wire logic [CFG_IDX_W-1:0] devCfgIdx,
    input wire logic [7:0] devCfgByte,
    // status
    input wire logic [63:0] acceptedFlags,
    input wire logic [31:0] progressFlags,
    input wire logic deviceResetPulse,
    input wire logic irqOut
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    logic ackWr, softRst, goWr, bellWr, progWr;
    logic [31:0] pickReg;

    // write decode, seen in the cycle the request is taken
    assign ackWr = busReq.wr && busReq.addr == OFS_IRQ_CLEAR;
    assign progWr = busReq.wr && busReq.addr == OFS_PROGRESS;
    assign softRst = progWr && busReq.wdata == 32'h0;
    assign goWr = busReq.wr && busReq.addr == OFS_RING_GO;
    assign bellWr = busReq.wr && busReq.addr == OFS_DOORBELL;

    // ring pick mirror; soft reset returns it to zero as well
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pickReg <= PICK_RESET;
        end else if (softRst) begin
            pickReg <= PICK_RESET;
        end else if (busReq.wr && busReq.addr == OFS_RING_PICK) begin
            pickReg <= busReq.wdata;
        end
    end

    chk_read_answer: assert property (
        rdValid == $past(busReq.rd))
        else $error("read answer not one cycle after read");
    chk_used_raises_irq: assert property (
        usedRingEvt |-> ##2 irqOut)
        else $error("used ring event did not raise irq");
    chk_cfg_raises_irq: assert property (
        devCfgWr |-> ##2 irqOut)
        else $error("settings change did not raise irq");
    // irq trails the cause bits by a cycle, so the clear seen one edge
    // back is the one that can still drop the line
    chk_cause_stays_set: assert property (
        irqOut && !$past(ackWr) && !$past(softRst) |=> irqOut)
        else $error("irq dropped without acknowledge");
    chk_ack_clears_irq: assert property (
        (ackWr && busReq.wdata[1:0] == 2'h3 && !usedRingEvt && !devCfgWr)
        ##1 (!usedRingEvt && !devCfgWr) |=> !irqOut)
        else $error("full acknowledge left irq high");
    chk_bell_pulse: assert property (
        doorbellPulse == $past(bellWr))
        else $error("doorbell pulse wrong");
    chk_bell_index: assert property (
        bellWr |=> doorbellIndex == $past(busReq.wdata))
        else $error("doorbell index wrong");
    chk_progress_sets: assert property (
        progWr && busReq.wdata != 32'h0 |=>
        (progressFlags & $past(busReq.wdata)) == $past(busReq.wdata))
        else $error("progress flags not set");
    chk_soft_reset: assert property (
        softRst |=> deviceResetPulse && progressFlags == 32'h0
        && acceptedFlags == 64'h0)
        else $error("soft reset incomplete");
    // pick and data taken two edges back, where the write was seen
    chk_go_mask: assert property (
        goWr && pickReg < NUM_RINGS |-> ##2
        ringGoMask[$past(pickReg[1:0], 2)] == $past(busReq.wdata[0], 2))
        else $error("go mask does not follow go write");

    // main scenarios reached
    cover property (usedRingEvt ##2 irqOut);
    cover property (softRst ##1 deviceResetPulse);
    cover property (goWr ##2 ringGoMask != 4'h0);
endmodule

bind mvdr_regs mvdr_regs_props i_props (.mclk(mclk), .rst(rst),
    .busReq(busReq), .rdData(rdData), .rdValid(rdValid),
    .offeredFlags(offeredFlags), .usedRingEvt(usedRingEvt),
    .viewIdx(viewIdx), .viewRing(viewRing), .ringGoMask(ringGoMask),
    .doorbellPulse(doorbellPulse), .doorbellIndex(doorbellIndex),
    .devCfgWr(devCfgWr), .devCfgIdx(devCfgIdx), .devCfgByte(devCfgByte),
    .acceptedFlags(acceptedFlags), .progressFlags(progressFlags),
    .deviceResetPulse(deviceResetPulse), .irqOut(irqOut));

/* File: tb/mvdr_regs_tb_top.sv */
// self-checking bench for the register bank, one task per scenario.
// assumes mvdr_pkg and the checker are compiled before this file.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end end

// ==========================================================
// bench top
module mvdr_regs_tb_top
    import mvdr_pkg::*;
;
    logic mclk, rst, rdValid, usedRingEvt, doorbellPulse;
    logic devCfgWr, deviceResetPulse, irqOut;
    mvdr_req_t busReq;
    mvdr_ring_t viewRing;
    logic [31:0] rdData, doorbellIndex, progressFlags, rv, ep;
    logic [63:0] offeredFlags, acceptedFlags;
    logic [RING_IDX_W-1:0] viewIdx;
    logic [NUM_RINGS-1:0] ringGoMask;
    logic [CFG_IDX_W-1:0] devCfgIdx;
    logic [7:0] devCfgByte;
    int mismatches, check_count;

    mvdr_regs i_dut (.mclk(mclk), .rst(rst), .busReq(busReq),
        .rdData(rdData), .rdValid(rdValid), .offeredFlags(offeredFlags),
        .usedRingEvt(usedRingEvt), .viewIdx(viewIdx), .viewRing(viewRing),
        .ringGoMask(ringGoMask), .doorbellPulse(doorbellPulse),
        .doorbellIndex(doorbellIndex), .devCfgWr(devCfgWr),
        .devCfgIdx(devCfgIdx), .devCfgByte(devCfgByte),
        .acceptedFlags(acceptedFlags), .progressFlags(progressFlags),
        .deviceResetPulse(deviceResetPulse), .irqOut(irqOut));

    // 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ======================================================
    // bus tasks; a gap cycle keeps strobes from being set twice at once
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] b = 4'hf);
        @(negedge mclk);
        busReq.wr = 1'b1;
        busReq.addr = a;
        busReq.wdata = d;
        busReq.be = b;
        @(negedge mclk);
        busReq.wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        int n;
        @(negedge mclk);
        busReq.rd = 1'b1;
        busReq.addr = a;
        busReq.be = 4'hf; // settings reads mask lanes by the enables
        @(negedge mclk);
        busReq.rd = 1'b0;
        n = 0;
        while (rdValid !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        if (n == 4) begin
            mismatches++;
            report_and_stop();
        end
        d = rdData;
    endtask

    task automatic expect_rd(input logic [11:0] a, input logic [31:0] e);
        rd_reg(a, rv);
        `CHK(rv, e); // shared read compare
    endtask

    task automatic pulse_used;
        @(negedge mclk);
        usedRingEvt = 1'b1;
        @(negedge mclk);
        usedRingEvt = 1'b0;
    endtask

    function automatic logic [31:0] bval(int r, logic [11:0] off);
        return {8'hc0, 8'(r), 4'h0, off};
    endfunction

    // ======================================================
    // scenarios
    task automatic t_features;
        offeredFlags = 64'h89ab_cdef_0123_4567;
        wr_reg(OFS_OFFERED_PICK, 32'h1);
        expect_rd(OFS_OFFERED_WORD, 32'h89ab_cdef);
        wr_reg(OFS_OFFERED_PICK, 32'h0);
        expect_rd(OFS_OFFERED_WORD, 32'h0123_4567);
        wr_reg(OFS_ACCEPTED_PICK, 32'h1);
        wr_reg(OFS_ACCEPTED_WORD, 32'h0000_00a5);
        wr_reg(OFS_ACCEPTED_PICK, 32'h0);
        wr_reg(OFS_ACCEPTED_WORD, 32'h5a5a_0001);
        `CHK(acceptedFlags, 64'h0000_00a5_5a5a_0001);
        expect_rd(OFS_ACCEPTED_WORD, 32'h0);
    endtask

    task automatic t_rings;
        logic [11:0] off;
        logic [63:0] exp64;
        for (int r = 0; r < NUM_RINGS; r++) begin
            wr_reg(OFS_RING_PICK, 32'(r));
            expect_rd(OFS_RING_GO, 32'h0);
            expect_rd(OFS_RING_LIMIT, {16'h0, RING_DEPTH_LIMIT});
            wr_reg(OFS_RING_DEPTH, 32'h10 + 32'(r));
            for (int k = 0; k < 6; k++) begin
                off = OFS_DESC_LO + 12'(16 * (k / 2) + 4 * (k % 2));
                wr_reg(off, bval(r, off));
            end
            wr_reg(OFS_RING_GO, 32'h1);
            expect_rd(OFS_RING_GO, 32'h1);
            expect_rd(OFS_RING_DEPTH, 32'h0);
            viewIdx = 2'(r);
            @(negedge mclk);
            `CHK(viewRing.depth, 16'h10 + 16'(r));
            `CHK(viewRing.go, 1'b1);
            exp64 = {bval(r, OFS_DESC_HI), bval(r, OFS_DESC_LO)};
            `CHK(viewRing.descBase, exp64);
            exp64 = {bval(r, OFS_OFFER_HI), bval(r, OFS_OFFER_LO)};
            `CHK(viewRing.offerBase, exp64);
            exp64 = {bval(r, OFS_DONE_HI), bval(r, OFS_DONE_LO)};
            `CHK(viewRing.doneBase, exp64);
            `CHK(ringGoMask, 4'((1 << (r + 1)) - 1));
        end
        wr_reg(OFS_RING_PICK, 32'h4);
        expect_rd(OFS_RING_LIMIT, 32'h0);
    endtask

    task automatic t_events;
        pulse_used();
        expect_rd(OFS_IRQ_CAUSE, 32'h1);
        `CHK(irqOut, 1'b1);
        wr_reg(OFS_IRQ_CAUSE, 32'h0);
        wr_reg(OFS_IRQ_CLEAR, 32'h2);
        expect_rd(OFS_IRQ_CAUSE, 32'h1);
        wr_reg(OFS_IRQ_CLEAR, 32'h3);
        expect_rd(OFS_IRQ_CAUSE, 32'h0);
        `CHK(irqOut, 1'b0);
    endtask

    task automatic t_settings;
        rd_reg(OFS_EPOCH, ep);
        wr_reg(OFS_CFG_BASE, 32'h0000_ab00, 4'h2);
        rd_reg(OFS_CFG_BASE, rv);
        `CHK(rv[15:8], 8'hab);
        expect_rd(OFS_EPOCH, ep + 32'h1);
        @(negedge mclk);
        devCfgWr = 1'b1;
        devCfgIdx = 4'h7;
        devCfgByte = 8'h5a;
        @(negedge mclk);
        devCfgWr = 1'b0;
        rd_reg(OFS_CFG_BASE + 12'h4, rv);
        `CHK(rv[31:24], 8'h5a);
        expect_rd(OFS_EPOCH, ep + 32'h2);
        expect_rd(OFS_IRQ_CAUSE, 32'h2);
        wr_reg(OFS_IRQ_CLEAR, 32'h2);
        expect_rd(OFS_IRQ_CAUSE, 32'h0);
        expect_rd(OFS_EPOCH, ep + 32'h2);
    endtask

    task automatic t_doorbell;
        @(negedge mclk);
        busReq.wr = 1'b1;
        busReq.addr = OFS_DOORBELL;
        busReq.wdata = 32'h2;
        @(negedge mclk);
        `CHK(doorbellPulse, 1'b1);
        `CHK(doorbellIndex, 32'h2);
        busReq.wr = 1'b0;
        @(negedge mclk);
        `CHK(doorbellPulse, 1'b0);
        expect_rd(OFS_DOORBELL, 32'h0);
    endtask

    task automatic t_progress;
        wr_reg(OFS_PROGRESS, 32'h3);
        expect_rd(OFS_PROGRESS, 32'h3);
        wr_reg(OFS_PROGRESS, 32'h4);
        expect_rd(OFS_PROGRESS, 32'h7);
        pulse_used();
        @(negedge mclk);
        busReq.wr = 1'b1;
        busReq.addr = OFS_PROGRESS;
        busReq.wdata = 32'h0;
        @(negedge mclk);
        `CHK(deviceResetPulse, 1'b1);
        busReq.wr = 1'b0;
        @(negedge mclk);
        `CHK(ringGoMask, 4'h0);
        `CHK(acceptedFlags, 64'h0);
        expect_rd(OFS_PROGRESS, 32'h0);
        expect_rd(OFS_IRQ_CAUSE, 32'h0);
    endtask

    task automatic report_and_stop;
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // reset held three cycles, then every scenario in turn
    initial begin
        busReq = '0;
        rst = 1'b1;
        offeredFlags = 64'h0;
        usedRingEvt = 1'b0;
        viewIdx = '0;
        devCfgWr = 1'b0;
        devCfgIdx = '0;
        devCfgByte = 8'h0;
        mismatches = 0;
        check_count = 0;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        `CHK(irqOut, 1'b0);
        t_features();
        t_rings();
        t_events();
        t_settings();
        t_doorbell();
        t_progress();
        report_and_stop();
    end
endmodule
